/* verilog/mhb_pkg.sv */
// constants for the mac header field builder
// Operation
// - time-slot packets: version 0, ack policy 0, retry 0, reserved bits 0
// - time-slot packets carry frame type 3, a data frame
// - time-slot delivery id top bit set, low bits hold stream index
// - time-slot secure bit follows current device security state
// - sequence control word is always 0000 for both packet kinds
// - time-slot access information is C000, more-frames bit set
// - management packets: control frame, access 8000, broadcast dest, host src
// - management packets carry subtype 1110 in bits 12:9
// - management packets always have the secure bit set
package mhb_pkg;
  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int HDR_WORDS = 5;
  localparam int FIFO_DEPTH = 4;
  localparam int STREAM_W = 3;
  // --------------------------------------------------------------
  // frame control field positions
  // --------------------------------------------------------------
  localparam int VER_LSB = 0;
  localparam int VER_MSB = 2;
  localparam int SEC_BIT = 3;
  localparam int ACK_LSB = 4;
  localparam int ACK_MSB = 5;
  localparam int FT_LSB = 6;
  localparam int FT_MSB = 8;
  localparam int ID_LSB = 9;
  localparam int ID_MSB = 12;
  localparam int RETRY_BIT = 13;
  localparam int RSVD_LSB = 14;
  localparam int RSVD_MSB = 15;
  // --------------------------------------------------------------
  // field values
  // --------------------------------------------------------------
  localparam logic [2:0] VERSION_VAL = 3'h0;
  localparam logic [1:0] ACK_POLICY_VAL = 2'h0;
  localparam logic [2:0] FT_DATA = 3'h3;
  localparam logic [2:0] FT_CONTROL = 3'h1;
  localparam logic DELIV_FLAG = 1'h1;
  localparam logic [3:0] SUBTYPE_APP = 4'he;
  localparam logic RETRY_VAL = 1'h0;
  localparam logic [1:0] RSVD_VAL = 2'h0;
  localparam logic [15:0] SEQ_CTRL_VAL = 16'h0000;
  localparam logic [15:0] ACC_DATA = 16'hc000;
  localparam logic [15:0] ACC_MMC = 16'h8000;
  // --------------------------------------------------------------
  // header word order on the output stream
  // --------------------------------------------------------------
  localparam logic [2:0] W_FC = 3'h0;
  localparam logic [2:0] W_DEST = 3'h1;
  localparam logic [2:0] W_SRC = 3'h2;
  localparam logic [2:0] W_SEQ = 3'h3;
  localparam logic [2:0] W_ACC = 3'h4;
  typedef enum logic [0:0] {ST_IDLE, ST_EMIT} mhb_state_e;
endpackage : mhb_pkg

/* verilog/mhb_builder.sv */
// mac header builder with its output fifo
`timescale 1ns/100ps
// ----------------------------------------------------------------
// fifo with registered output stage
// ----------------------------------------------------------------
module mhb_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic push, pop;

  // pointer step with wrap, shared by both pointers
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : step

  // output stage refills whenever it is empty or being taken
  always_comb begin
    push = in_valid_i && (cnt_q != CW'(DEPTH));
    pop = (cnt_q != '0) && (!ov_q || out_ready_i);
    wr_d = push ? step(wr_q) : wr_q;
    rd_d = pop ? step(rd_q) : rd_q;
    cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
    ov_d = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
    od_d = pop ? mem_q[rd_q] : od_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // ready is plain count compare so a stalled sink stalls the builder
  assign in_ready_o = (cnt_q != CW'(DEPTH));
  assign out_valid_o = ov_q;
  assign out_data_o = od_q;
endmodule : mhb_fifo

// ----------------------------------------------------------------
// header builder top
// ----------------------------------------------------------------
module mhb_builder (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_MMC_I,
  input wire logic REQ_TO_HOST_I,
  input wire logic SECURE_STATE_I,
  input wire logic [2:0] STREAM_IDX_I,
  input wire logic [15:0] DEV_ADDR_I,
  input wire logic [15:0] HOST_ADDR_I,
  input wire logic [15:0] BCAST_ADDR_I,
  output logic HDR_VALID_O,
  input wire logic HDR_READY_I,
  output logic [15:0] HDR_DATA_O,
  output logic HDR_LAST_O
);
  localparam int FW = mhb_pkg::WORD_W + 1;
  mhb_pkg::mhb_state_e st_q, st_d;
  logic [2:0] idx_q, idx_d;
  logic rdy_q, rdy_d;
  logic mmc_q, mmc_d, toh_q, toh_d, sec_q, sec_d;
  logic [2:0] strm_q, strm_d;
  logic [15:0] dev_q, dev_d, host_q, host_d, bc_q, bc_d;
  logic f_ready, f_valid, push;
  logic [15:0] word;
  logic [FW-1:0] f_out;

  // one header word by index; fixed fields come from constants, except the management secure bit, a literal 1
  function automatic logic [15:0] hdr_word(input logic [2:0] i, input logic mmc,
                                           input logic toh, input logic sec,
                                           input logic [2:0] strm, input logic [15:0] dev,
                                           input logic [15:0] host, input logic [15:0] bc);
    logic [15:0] fc;
    fc = '0;
    fc[mhb_pkg::VER_MSB:mhb_pkg::VER_LSB] = mhb_pkg::VERSION_VAL;
    fc[mhb_pkg::ACK_MSB:mhb_pkg::ACK_LSB] = mhb_pkg::ACK_POLICY_VAL;
    fc[mhb_pkg::RETRY_BIT] = mhb_pkg::RETRY_VAL;
    fc[mhb_pkg::RSVD_MSB:mhb_pkg::RSVD_LSB] = mhb_pkg::RSVD_VAL;
    if (mmc) begin
      fc[mhb_pkg::FT_MSB:mhb_pkg::FT_LSB] = mhb_pkg::FT_CONTROL;
      fc[mhb_pkg::ID_MSB:mhb_pkg::ID_LSB] = mhb_pkg::SUBTYPE_APP;
      fc[mhb_pkg::SEC_BIT] = 1'b1;
    end else begin
      fc[mhb_pkg::FT_MSB:mhb_pkg::FT_LSB] = mhb_pkg::FT_DATA;
      fc[mhb_pkg::ID_MSB:mhb_pkg::ID_LSB] = {mhb_pkg::DELIV_FLAG, strm};
      fc[mhb_pkg::SEC_BIT] = sec;
    end
    if (i == mhb_pkg::W_FC) begin
      hdr_word = fc;
    end else if (i == mhb_pkg::W_DEST) begin
      hdr_word = mmc ? bc : (toh ? host : dev);
    end else if (i == mhb_pkg::W_SRC) begin
      hdr_word = (mmc || !toh) ? host : dev;
    end else if (i == mhb_pkg::W_SEQ) begin
      hdr_word = mhb_pkg::SEQ_CTRL_VAL;
    end else begin
      hdr_word = mmc ? mhb_pkg::ACC_MMC : mhb_pkg::ACC_DATA;
    end
  endfunction : hdr_word

  // request capture and word sequencing; fields are frozen per header
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    {mmc_d, toh_d, sec_d, strm_d} = {mmc_q, toh_q, sec_q, strm_q};
    {dev_d, host_d, bc_d} = {dev_q, host_q, bc_q};
    word = hdr_word(idx_q, mmc_q, toh_q, sec_q, strm_q, dev_q, host_q, bc_q);
    push = (st_q == mhb_pkg::ST_EMIT) && f_ready;
    case (st_q)
      mhb_pkg::ST_IDLE: begin
        if (REQ_VALID_I && rdy_q) begin
          st_d = mhb_pkg::ST_EMIT;
          idx_d = mhb_pkg::W_FC;
          {mmc_d, toh_d, sec_d, strm_d} = {REQ_MMC_I, REQ_TO_HOST_I, SECURE_STATE_I,
                                           STREAM_IDX_I};
          {dev_d, host_d, bc_d} = {DEV_ADDR_I, HOST_ADDR_I, BCAST_ADDR_I};
        end
      end
      default: begin
        if (push) begin
          if (idx_q == mhb_pkg::W_ACC) begin
            st_d = mhb_pkg::ST_IDLE;
          end else begin
            idx_d = 3'(idx_q + 3'h1);
          end
        end
      end
    endcase
    rdy_d = (st_d == mhb_pkg::ST_IDLE);
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q <= mhb_pkg::ST_IDLE;
      idx_q <= 3'h0;
      rdy_q <= 1'b0;
      {mmc_q, toh_q, sec_q, strm_q} <= '0;
      {dev_q, host_q, bc_q} <= '0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      rdy_q <= rdy_d;
      {mmc_q, toh_q, sec_q, strm_q} <= {mmc_d, toh_d, sec_d, strm_d};
      {dev_q, host_q, bc_q} <= {dev_d, host_d, bc_d};
    end
  end

  // four words of buffering plus the output stage hold a full header
  mhb_fifo #(.WIDTH(FW), .DEPTH(mhb_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .in_valid_i(push),
    .in_ready_o(f_ready),
    .in_data_i({idx_q == mhb_pkg::W_ACC, word}),
    .out_valid_o(f_valid),
    .out_ready_i(HDR_READY_I),
    .out_data_o(f_out)
  );

  assign REQ_READY_O = rdy_q;
  assign HDR_VALID_O = f_valid;
  assign HDR_DATA_O = f_out[15:0];
  assign HDR_LAST_O = f_out[16];

  // --------------------------------------------------------------
  // checks on header words entering and leaving the buffer and on request ready
  // --------------------------------------------------------------
  logic push_fc, push_data_fc, push_mmc_fc;
  assign push_fc = push && (idx_q == mhb_pkg::W_FC);
  assign push_data_fc = push_fc && !mmc_q;
  assign push_mmc_fc = push_fc && mmc_q;

  a_fixed_fc_bits: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push_fc |-> (word[2:0] == 3'h0 && word[5:4] == 2'h0 && word[15:13] == 3'h0))
    else $error("fixed frame control bits wrong");
  a_data_type: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push_data_fc |-> word[8:6] == 3'h3) else $error("data frame type wrong");
  a_deliv_id: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push_data_fc |-> word[12:9] == {1'b1, strm_q}) else $error("delivery id wrong");
  // state is frozen at take, so the word must carry the level seen on that edge
  a_secure_state: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    ((REQ_VALID_I && REQ_READY_O && !REQ_MMC_I) |=> sec_q == $past(SECURE_STATE_I))
    and (push_data_fc |-> word[3] == sec_q))
    else $error("secure bit does not follow state");
  a_seq_zero: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push && idx_q == 3'h3 |-> word == 16'h0000) else $error("sequence control not zero");
  a_access_data: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push && idx_q == 3'h4 && !mmc_q |-> word == 16'hc000)
    else $error("data access info wrong");
  // the word flagged last on the output must be an access information word
  a_last_word: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    HDR_VALID_O && HDR_LAST_O |-> (HDR_DATA_O == 16'hc000 || HDR_DATA_O == 16'h8000))
    else $error("last flag on a non access word");
  a_addr_swap: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push && idx_q == 3'h1 && !mmc_q |-> word == (toh_q ? host_q : dev_q))
    else $error("data destination wrong");
  a_mmc_fields: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push && mmc_q |-> (idx_q != 3'h1 || word == bc_q) && (idx_q != 3'h2 || word == host_q)
    && (idx_q != 3'h4 || word == 16'h8000) && (idx_q != 3'h0 || word[8:6] == 3'h1))
    else $error("management header field wrong");
  a_mmc_subtype: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push_mmc_fc |-> word[12:9] == 4'he) else $error("management subtype wrong");
  a_mmc_secure: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push_mmc_fc |-> word[3]) else $error("management secure bit clear");
  // ready returns the edge after the fifth push whenever the buffer had room
  a_header_len: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (REQ_VALID_I && REQ_READY_O) ##1 f_ready [*5] |=> REQ_READY_O)
    else $error("header not emitted in five cycles");
  // five words always take at least five edges, stalled sink or not
  a_ready_hold: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (REQ_VALID_I && REQ_READY_O) |=> !REQ_READY_O [*5])
    else $error("request ready returned too early");

  c_data_hdr: cover property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push_data_fc ##[1:8] (push && idx_q == 3'h4));
  c_mmc_hdr: cover property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    push_mmc_fc ##[1:8] (push && idx_q == 3'h4));
  c_stall_full: cover property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (HDR_VALID_O && !HDR_READY_I && !f_ready));
endmodule : mhb_builder

/* dv/mhb_sink_model.sv */
// header word sink standing in for the peer mac layer
`timescale 1ns/100ps
// ----------------------------------------------------------------
// sink: always ready, alternating stall, or full stall
// ----------------------------------------------------------------
module mhb_sink_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] mode_i,
  output logic ready_o
);
  logic tog_q;
  logic tog_d;
  // free toggle gives the alternating stall pattern
  always_comb begin
    tog_d = ~tog_q;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end
  // a real peer may stall at any time, so no mode waits for valid
  always_comb begin
    case (mode_i)
      2'h0: ready_o = 1'b1;
      2'h1: ready_o = tog_q;
      default: ready_o = 1'b0;
    endcase
  end
endmodule : mhb_sink_model

/* dv/mhb_builder_bench.sv */
// self-checking bench for the mac header builder
`timescale 1ns/100ps
module mhb_builder_bench;
  logic clk, rst_n, req_valid, req_ready, req_mmc, req_to_host, secure_state;
  logic [2:0] stream_idx;
  logic [15:0] dev_addr, host_addr, bcast_addr, hdr_data;
  logic hdr_valid, hdr_ready, hdr_last;
  logic [1:0] sink_mode;
  int fails, samples_checked, cycles;
  logic [16:0] got_q[$];
  logic [16:0] exp_q[$];
  // ----------------------------------------------------------------
  // design, sink and clock
  // ----------------------------------------------------------------
  mhb_builder uut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .REQ_VALID_I(req_valid),
    .REQ_READY_O(req_ready), .REQ_MMC_I(req_mmc), .REQ_TO_HOST_I(req_to_host),
    .SECURE_STATE_I(secure_state), .STREAM_IDX_I(stream_idx), .DEV_ADDR_I(dev_addr),
    .HOST_ADDR_I(host_addr), .BCAST_ADDR_I(bcast_addr), .HDR_VALID_O(hdr_valid),
    .HDR_READY_I(hdr_ready), .HDR_DATA_O(hdr_data), .HDR_LAST_O(hdr_last));
  mhb_sink_model sink (.clk_i(clk), .rst_n_i(rst_n), .mode_i(sink_mode), .ready_o(hdr_ready));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // collect accepted words; timeout cuts a hang short
  always @(posedge clk) begin
    if (rst_n === 1'b1 && hdr_valid === 1'b1 && hdr_ready === 1'b1) begin
      got_q.push_back({hdr_last, hdr_data});
    end
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // request held until taken; expected words worked out from field values
  task automatic send(input logic mmc, input logic toh, input logic sec, input logic [2:0] strm);
    logic [15:0] fc, dst, src;
    req_valid = 1'b1;
    req_mmc = mmc;
    req_to_host = toh;
    secure_state = sec;
    stream_idx = strm;
    if (mmc) begin
      fc = {2'b00, 1'b0, 4'b1110, 3'b001, 2'b00, 1'b1, 3'b000};
      dst = bcast_addr;
      src = host_addr;
    end else begin
      fc = {2'b00, 1'b0, 1'b1, strm, 3'b011, 2'b00, sec, 3'b000};
      dst = toh ? host_addr : dev_addr;
      src = toh ? dev_addr : host_addr;
    end
    exp_q.push_back({1'b0, fc});
    exp_q.push_back({1'b0, dst});
    exp_q.push_back({1'b0, src});
    exp_q.push_back({1'b0, 16'h0000});
    exp_q.push_back({1'b1, mmc ? 16'h8000 : 16'hc000});
    while (req_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 1'b0;
    // one idle edge so a following call never re-raises valid in the same step
    @(posedge clk) #1;
  endtask : send
  // wait for all expected words, then compare in order
  task automatic drain();
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 300) begin
      @(posedge clk) #1;
      n++;
    end
    check(17'(got_q.size()), 17'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask : drain
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_data_both_dirs();
    send(1'b0, 1'b0, 1'b0, 3'h0);
    drain();
    sink_mode = 2'h1;
    send(1'b0, 1'b1, 1'b1, 3'h7);
    send(1'b0, 1'b0, 1'b1, 3'h5);
    drain();
    sink_mode = 2'h0;
  endtask : t_data_both_dirs
  // direction and secure state must not leak into management headers
  task automatic t_mmc();
    send(1'b1, 1'b1, 1'b0, 3'h3);
    send(1'b1, 1'b0, 1'b1, 3'h0);
    drain();
  endtask : t_mmc
  // full stall: five words fit, a second header then cannot finish
  task automatic t_full_stall();
    sink_mode = 2'h2;
    send(1'b0, 1'b0, 1'b1, 3'h2);
    repeat (10) @(posedge clk) #1;
    check({16'h0000, req_ready}, 17'h0_0001);
    check({hdr_valid, hdr_data}, {1'b1, exp_q[0][15:0]});
    send(1'b0, 1'b1, 1'b0, 3'h6);
    repeat (10) @(posedge clk) #1;
    check({16'h0000, req_ready}, 17'h0_0000);
    sink_mode = 2'h0;
    drain();
  endtask : t_full_stall
  task automatic tally_and_finish();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_mmc = 1'b0;
    req_to_host = 1'b0;
    secure_state = 1'b0;
    stream_idx = 3'h0;
    dev_addr = 16'h1a2b;
    host_addr = 16'h3c4d;
    bcast_addr = 16'h5e6f;
    sink_mode = 2'h0;
    repeat (6) @(posedge clk);
    #1;
    check({15'h0000, req_ready, hdr_valid}, 17'h0_0000);
    check({hdr_last, hdr_data}, 17'h0_0000);
    rst_n = 1'b1;
    @(posedge clk) #1;
    t_data_both_dirs();
    dev_addr = 16'h0081;
    host_addr = 16'h00f0;
    t_mmc();
    t_full_stall();
    tally_and_finish();
  end
endmodule : mhb_builder_bench
